// file: rtl/pbrt_read_ctrl.sv
// read-side bus controller: single and line read transfers
//
// Behaviour
// RULE1: instruction fetches start at half-line aligned address
// RULE2: byte, word, long and line cycles supported
// RULE3: burst-inhibited line finished with three long reads
// RULE4: all bus signals on rising clock edge
// RULE5: cache inhibit input ignored on single reads
// RULE6: single reads when cache off or uncachable
// RULE7: start clock drives address, attributes, read, cache_inhibit_out_n
// RULE8: start clock asserts strobe and in-progress
// RULE9: transfer-start strobe lasts exactly one clock
// RULE10: slave drives byte lanes per size, address
// RULE11: slave acknowledges after zero or more waits
// RULE12: sample ack each clock; latch data on ack
// RULE13: in-progress held if next cycle ready, else drop
// RULE14: line reads move four aligned long words
// RULE15: slave wraps address bits three and two
// RULE16: address and attributes held stable for burst
// RULE17: burst inhibit forces three long-word cycles
// RULE18: inhibited line stays one indivisible transfer
// RULE19: burst inhibit examined on first beat only
// RULE20: cache inhibit latched on first line beat only
// RULE21: low address bits kept through follow-ups
// RULE22: master steps address bits three and two
// RULE23: reset leaves strobes negated and bus idle
`timescale 1ns/1ps
module pbrt_read_ctrl
  import pbrt_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // access request from the memory units
  input wire logic req_valid_i,
  input wire logic [31:0] req_addr_i,
  input wire logic req_line_i,
  input wire logic req_instr_i,
  input wire logic [1:0] req_size_i,
  input wire logic req_cache_en_i,
  input wire logic req_cachable_i,
  input wire logic req_implicit_nc_i,
  input wire logic req_no_alloc_i,
  input wire logic [1:0] req_transfer_type_i,
  input wire logic [2:0] req_transfer_modifier_i,
  input wire logic req_page_user_bit1_i,
  input wire logic req_page_user_bit0_i,
  output logic req_ready_o,
  // answer to the memory units
  output logic rsp_valid_o,
  output logic [31:0] rsp_data_o,
  output logic [1:0] rsp_beat_o,
  output logic rsp_last_o,
  output logic rsp_cache_inhibit_o,
  // external bus
  output logic [31:0] bus_addr_o,
  output logic [1:0] transfer_type_o,
  output logic [2:0] transfer_modifier_o,
  output logic [1:0] user_page_attr_o,
  output logic size_hi_o,
  output logic size_lo_o,
  output logic read_write_o,
  output logic cache_inhibit_out_n_o,
  output logic transfer_start_n_o,
  output logic transfer_in_progress_n_o,
  input wire logic [31:0] bus_data_i,
  input wire logic transfer_ack_n_i,
  input wire logic burst_inhibit_n_i,
  input wire logic cache_inhibit_in_n_i
);
  pbrt_state_t state_reg;
  pbrt_state_t state_next;
  logic [31:0] addr_reg;
  logic [1:0] size_reg;
  logic line_reg;
  logic inhibited_reg;
  logic [1:0] beat_reg;
  logic [1:0] tt_reg;
  logic [2:0] tm_reg;
  logic [1:0] upa_reg;
  logic cache_inhibit_out_n_n_reg;
  logic ts_n_reg;
  logic tip_n_reg;
  logic ready_reg;
  logic rsp_valid_reg;
  logic [31:0] rsp_data_reg;
  logic [1:0] rsp_beat_reg;
  logic rsp_last_reg;
  logic rsp_ci_reg;
  logic ci_first_reg;
  logic rw_reg;

  wire use_line;
  wire [31:0] start_addr;
  wire [1:0] start_size;
  wire take_req;
  wire ack;
  wire first_beat;
  wire beat_last;
  wire inhibit_now;
  wire ci_now;
  wire follow_up;
  wire more_cycles;
  wire [31:0] step_addr;
  wire [1:0] beat_inc;
  wire single_long;
  wire wait_ack;

  // line only when cache on, page cachable and the miss allocates
  assign use_line = req_line_i & req_cache_en_i & req_cachable_i
    & ~req_implicit_nc_i & ~req_no_alloc_i; // [RULE6] [RULE14]
  // instruction fetch rounds down to the half-line
  assign start_addr = req_instr_i ?
    {req_addr_i[31:PBRT_ALIGN_LSB], 3'h0} : req_addr_i; // [RULE1]
  // fall-back singles of a line and fetches go out as long words
  assign single_long = req_instr_i | req_line_i
    | (req_size_i == PBRT_SIZE_LINE); // [RULE6]
  assign start_size = use_line ? PBRT_SIZE_LINE :
    (single_long ? PBRT_SIZE_LONG : req_size_i); // [RULE2]
  assign take_req = req_valid_i & ready_reg & (state_reg == PBRT_IDLE);
  assign ack = ~transfer_ack_n_i; // [RULE4] [RULE11]
  // an ack seen during the start clock belongs to no cycle
  assign wait_ack = ack & (state_reg == PBRT_WAIT); // [RULE12]
  assign first_beat = line_reg & ~inhibited_reg & (beat_reg == 2'h0);
  // burst inhibit only counts on the first beat of a line
  assign inhibit_now = first_beat & ~burst_inhibit_n_i; // [RULE19]
  assign ci_now = first_beat & ~cache_inhibit_in_n_i; // [RULE5] [RULE20]
  assign beat_last = ~line_reg | (beat_reg == PBRT_BEATS_LAST);
  assign follow_up = ack & (state_reg == PBRT_WAIT) & line_reg
    & (inhibited_reg | inhibit_now) & ~beat_last; // [RULE3] [RULE17]
  assign more_cycles = follow_up | (req_valid_i & ~ack)
    | (req_valid_i & beat_last); // [RULE13]
  assign beat_inc = beat_reg + 2'h1;

  pbrt_addr_step u_addr_step
  (
    .addr_i(addr_reg),
    .addr_o(step_addr)
  );

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      PBRT_IDLE:
      begin
        if (take_req)
        begin
          state_next = PBRT_START;
        end
      end
      PBRT_START:
      begin
        state_next = PBRT_WAIT;
      end
      PBRT_WAIT:
      begin
        if (ack & follow_up)
        begin
          state_next = PBRT_START; // [RULE18]
        end
        else if (ack & beat_last)
        begin
          state_next = PBRT_IDLE;
        end
      end
      default:
      begin
        state_next = PBRT_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= PBRT_IDLE; // [RULE23]
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // address and attribute registers: steady for a burst line; the address steps on inhibited follow-ups
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      addr_reg <= PBRT_ADDR_RESET;
      line_reg <= 1'b0;
      tt_reg <= 2'h0;
      tm_reg <= 3'h0;
      upa_reg <= 2'h0;
      cache_inhibit_out_n_n_reg <= 1'b1;
    end
    else if (take_req)
    begin
      addr_reg <= start_addr; // [RULE7] [RULE21]
      line_reg <= use_line;
      tt_reg <= req_transfer_type_i;
      tm_reg <= req_transfer_modifier_i;
      upa_reg <= {req_page_user_bit1_i, req_page_user_bit0_i};
      cache_inhibit_out_n_n_reg <= use_line; // [RULE7]
    end
    else if (follow_up)
    begin
      addr_reg <= step_addr; // [RULE22] [RULE21]
    end
  end

  // bus size: follow-ups of an inhibited line go out as long words
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      size_reg <= PBRT_SIZE_LONG;
    end
    else if (take_req)
    begin
      size_reg <= start_size; // [RULE2]
    end
    else if (follow_up)
    begin
      size_reg <= PBRT_SIZE_LONG; // [RULE3] [RULE17]
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      inhibited_reg <= 1'b0;
      beat_reg <= 2'h0;
      ci_first_reg <= 1'b0;
    end
    else if (take_req)
    begin
      inhibited_reg <= 1'b0;
      beat_reg <= 2'h0;
      ci_first_reg <= 1'b0;
    end
    else if (wait_ack)
    begin
      beat_reg <= beat_inc;
      if (inhibit_now)
      begin
        inhibited_reg <= 1'b1; // [RULE17]
      end
      if (ci_now)
      begin
        ci_first_reg <= 1'b1; // [RULE20]
      end
    end
  end

  // start strobe lasts one clock per bus cycle
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ts_n_reg <= 1'b1; // [RULE23]
      rw_reg <= 1'b1;
    end
    else
    begin
      ts_n_reg <= ~(take_req | follow_up); // [RULE8] [RULE9]
      rw_reg <= 1'b1; // [RULE7]
    end
  end

  // in-progress from the first start to the end of the line
  // a pending request keeps it low so back-to-back cycles do not glitch
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      tip_n_reg <= 1'b1; // [RULE23]
    end
    else if (take_req | follow_up)
    begin
      tip_n_reg <= 1'b0; // [RULE8]
    end
    else if (wait_ack & beat_last & ~more_cycles)
    begin
      tip_n_reg <= 1'b1; // [RULE13]
    end
  end

  // accept a request only between lines, so nothing splits one
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ready_reg <= 1'b0;
    end
    else
    begin
      ready_reg <= (state_next == PBRT_IDLE) & ~take_req; // [RULE18]
    end
  end

  // data is latched only on an edge that carries acknowledge
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= PBRT_DATA_RESET;
      rsp_beat_reg <= 2'h0;
      rsp_last_reg <= 1'b0;
      rsp_ci_reg <= 1'b0;
    end
    else
    begin
      rsp_valid_reg <= wait_ack; // [RULE12]
      if (wait_ack)
      begin
        rsp_data_reg <= bus_data_i; // [RULE12] [RULE10]
        rsp_beat_reg <= beat_reg;
        rsp_last_reg <= beat_last;
        rsp_ci_reg <= line_reg & (ci_first_reg | ci_now); // [RULE5]
      end
    end
  end

  assign req_ready_o = ready_reg;
  assign rsp_valid_o = rsp_valid_reg;
  assign rsp_data_o = rsp_data_reg;
  assign rsp_beat_o = rsp_beat_reg;
  assign rsp_last_o = rsp_last_reg;
  assign rsp_cache_inhibit_o = rsp_ci_reg;
  assign bus_addr_o = addr_reg; // [RULE16]
  assign transfer_type_o = tt_reg;
  assign transfer_modifier_o = tm_reg;
  assign user_page_attr_o = upa_reg;
  assign size_hi_o = size_reg[1]; // [RULE2]
  assign size_lo_o = size_reg[0];
  assign read_write_o = rw_reg; // [RULE7]
  assign cache_inhibit_out_n_o = cache_inhibit_out_n_n_reg;
  assign transfer_start_n_o = ts_n_reg;
  assign transfer_in_progress_n_o = tip_n_reg;
endmodule

// file: rtl/pbrt_pkg.sv
// shared constants and types for the processor bus read controller
package pbrt_pkg;
  localparam logic [1:0] PBRT_SIZE_LONG = 2'h0;
  localparam logic [1:0] PBRT_SIZE_BYTE = 2'h1;
  localparam logic [1:0] PBRT_SIZE_WORD = 2'h2;
  localparam logic [1:0] PBRT_SIZE_LINE = 2'h3;
  localparam logic [1:0] PBRT_BEATS_LAST = 2'h3;
  localparam logic [31:0] PBRT_ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] PBRT_DATA_RESET = 32'h0000_0000;
  localparam int PBRT_ALIGN_LSB = 3;

  typedef enum logic [1:0] {
    PBRT_IDLE = 2'b00,
    PBRT_START = 2'b01,
    PBRT_WAIT = 2'b10
  } pbrt_state_t;
endpackage

// file: rtl/pbrt_addr_step.sv
// long-word address step for line follow-up cycles
`timescale 1ns/1ps
module pbrt_addr_step
(
  // current address
  input wire logic [31:0] addr_i,
  // stepped address
  output logic [31:0] addr_o
);
  wire [1:0] lw_next;

  assign lw_next = addr_i[3:2] + 2'h1;
  // wrap within the 16-byte block, keep a1..a0 untouched
  assign addr_o = {addr_i[31:4], lw_next, addr_i[1:0]};
endmodule

// file: sim/pbrt_read_checker.sv
// bus-side assertions for the read controller
`timescale 1ns/1ps
module pbrt_read_checker
(
  // watched ports
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic rsp_valid_o,
  input wire logic rsp_last_o,
  input wire logic [31:0] bus_addr_o,
  input wire logic size_hi_o,
  input wire logic size_lo_o,
  input wire logic read_write_o,
  input wire logic transfer_start_n_o,
  input wire logic transfer_in_progress_n_o,
  input wire logic transfer_ack_n_i,
  input wire logic burst_inhibit_n_i
);
  logic first_reg;
  // ack in the start clock does not count
  wire ack = !transfer_ack_n_i && transfer_start_n_o &&
             !transfer_in_progress_n_o;
  wire line = size_hi_o && size_lo_o;
  wire [31:0] stepped = {bus_addr_o[31:4], bus_addr_o[3:2] + 2'h1,
                         bus_addr_o[1:0]};
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge core_clk_i)
    if (rst_i)
      first_reg <= 1'h0;
    else if (!transfer_start_n_o)
      first_reg <= 1'h1;
    else if (ack)
      first_reg <= 1'h0;
  sequence s_first_inhibit;
    first_reg && ack && !burst_inhibit_n_i && line;
  endsequence
  sequence s_follow_up;
    !transfer_start_n_o && !size_hi_o && !size_lo_o;
  endsequence
  property p_start_one;
    $fell(transfer_start_n_o) |=> transfer_start_n_o;
  endproperty
  a_start_one: assert property (p_start_one) else $error("start wide");
  property p_tip_cover;
    !transfer_start_n_o |-> !transfer_in_progress_n_o;
  endproperty
  a_tip_cover: assert property (p_tip_cover) else $error("tip off");
  property p_read_dir;
    !transfer_in_progress_n_o |-> read_write_o;
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("not read");
  property p_ack_rsp;
    ack |=> rsp_valid_o;
  endproperty
  a_ack_rsp: assert property (p_ack_rsp) else $error("ack lost");
  property p_rsp_cause;
    rsp_valid_o |-> $past(ack);
  endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("stray rsp");
  property p_tip_end;
    rsp_valid_o && rsp_last_o |->
      transfer_in_progress_n_o == !$past(req_valid_i);
  endproperty
  a_tip_end: assert property (p_tip_end) else $error("tip end");
  property p_inhibit_step;
    s_first_inhibit |=> s_follow_up ##0 bus_addr_o == $past(stepped);
  endproperty
  a_inhibit_step: assert property (p_inhibit_step) else $error("step");
  property p_burst_hold;
    !first_reg && ack && line |=> transfer_start_n_o;
  endproperty
  a_burst_hold: assert property (p_burst_hold) else $error("late bi");
  property p_addr_hold;
    line && transfer_start_n_o && !transfer_in_progress_n_o |->
      $stable(bus_addr_o);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("addr moved");
endmodule

bind pbrt_read_ctrl pbrt_read_checker chk_u (.*);

// file: sim/pbrt_slave_model.sv
// memory slave answering read cycles
`timescale 1ns/1ps
module pbrt_slave_model
(
  // bus from the controller
  input wire logic core_clk_i,
  input wire logic [31:0] addr_i,
  input wire logic line_i,
  input wire logic ts_n_i,
  // behaviour knobs
  input wire logic [1:0] waits_i,
  input wire logic inhibit_i,
  input wire logic late_i,
  input wire logic ci_i,
  // answer
  output logic [31:0] data_o = 32'h0,
  output logic ack_n_o = 1'h1,
  output logic bi_n_o = 1'h1,
  output logic ci_n_o = 1'h1
);
  logic go = 1'h0;
  logic first;
  logic [1:0] w, wa, n;
  always @(posedge core_clk_i)
  begin
    ack_n_o <= 1'h1;
    bi_n_o <= 1'h1;
    ci_n_o <= 1'h1;
    // idle bus inverts the data every clock, so the last word shows again every other clock
    data_o <= ~data_o;
    if (!ts_n_i)
    begin
      go = 1'h1;
      w = waits_i;
      wa = addr_i[3:2];
      n = {2{line_i}};
      first = 1'h1;
    end
    if (go && w != 2'h0)
      w = w - 2'h1;
    else if (go)
    begin
      ack_n_o <= 1'h0;
      data_o <= {addr_i[31:4], wa, 2'h0} ^ 32'h5A5A_5A5A;
      bi_n_o <= !(first ? inhibit_i : late_i);
      ci_n_o <= !(first ? ci_i : late_i);
      go = !(n == 2'h0 || (first && inhibit_i));
      n = n - 2'h1;
      wa = wa + 2'h1;
      first = 1'h0;
      w = waits_i;
    end
  end
endmodule

// file: sim/processor_bus_read_transfers_tb.sv
// self-checking bench for the read controller
`timescale 1ns/1ps
module processor_bus_read_transfers_tb
  import pbrt_pkg::*;
;
  typedef struct {
    logic ln, ins;
    logic [1:0] sz;
    logic [31:0] a;
    logic [1:0] w;
    logic inh, late, ci;
  } pbrt_row_t;
  pbrt_row_t rows [8] = '{
    '{1'h0, 1'h0, PBRT_SIZE_LONG, 32'h1000, 2'h0, 1'h0, 1'h0, 1'h1},
    '{1'h0, 1'h0, PBRT_SIZE_BYTE, 32'h1101, 2'h2, 1'h0, 1'h0, 1'h1},
    '{1'h0, 1'h0, PBRT_SIZE_WORD, 32'h2202, 2'h1, 1'h0, 1'h0, 1'h0},
    '{1'h0, 1'h1, PBRT_SIZE_LONG, 32'h300C, 2'h0, 1'h0, 1'h0, 1'h0},
    '{1'h1, 1'h0, PBRT_SIZE_LINE, 32'h400C, 2'h0, 1'h0, 1'h0, 1'h1},
    '{1'h1, 1'h0, PBRT_SIZE_LINE, 32'h5006, 2'h1, 1'h1, 1'h0, 1'h1},
    '{1'h1, 1'h0, PBRT_SIZE_LINE, 32'h6004, 2'h0, 1'h0, 1'h1, 1'h0},
    '{1'h1, 1'h0, PBRT_SIZE_LINE, 32'h700B, 2'h2, 1'h1, 1'h1, 1'h0}};
  logic core_clk_i, rst_i = 1'h1, req_valid_i = 1'h0, req_line_i = 1'h0;
  logic req_instr_i = 1'h0, req_cache_en_i = 1'h0, req_cachable_i = 1'h0;
  logic req_implicit_nc_i = 1'h0, req_no_alloc_i = 1'h0;
  logic req_page_user_bit1_i = 1'h0, req_page_user_bit0_i = 1'h0;
  logic [31:0] req_addr_i = 32'h0, rsp_data_o, bus_addr_o, bus_data_i, ea;
  logic [1:0] req_size_i = 2'h0, req_transfer_type_i = 2'h0, wt = 2'h0;
  logic [2:0] req_transfer_modifier_i = 3'h0, transfer_modifier_o;
  logic [1:0] rsp_beat_o, transfer_type_o, user_page_attr_o, szx;
  logic req_ready_o, rsp_valid_o, rsp_last_o, rsp_cache_inhibit_o, ln;
  logic size_hi_o, size_lo_o, read_write_o, cache_inhibit_out_n_o;
  logic transfer_start_n_o, transfer_in_progress_n_o, transfer_ack_n_i;
  logic burst_inhibit_n_i, cache_inhibit_in_n_i;
  logic inh = 1'h0, late = 1'h0, ci = 1'h0;
  int bad_count = 0, comparisons = 0, tk = 0, tk0 = 0, cyc = 0;
  pbrt_read_ctrl dut_u (.*);
  pbrt_slave_model slave_u (.core_clk_i, .addr_i(bus_addr_o),
    .line_i(size_hi_o & size_lo_o), .ts_n_i(transfer_start_n_o),
    .waits_i(wt), .inhibit_i(inh), .late_i(late), .ci_i(ci),
    .data_o(bus_data_i), .ack_n_o(transfer_ack_n_i),
    .bi_n_o(burst_inhibit_n_i), .ci_n_o(cache_inhibit_in_n_i));
  initial
  begin
    core_clk_i = 1'h0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [47:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc > 4000)
    begin
      bad_count++;
      $display("MISMATCH t=%0t timeout", $time);
      print_verdict();
    end
  end
  always @(posedge core_clk_i)
    if (!rst_i && transfer_start_n_o === 1'h0)
    begin
      chk({bus_addr_o, size_hi_o, size_lo_o, cache_inhibit_out_n_o,
        read_write_o, transfer_type_o, transfer_modifier_o,
        user_page_attr_o}, {ea[31:4], ea[3:2] + 2'(tk - tk0), ea[1:0],
        tk == tk0 ? szx : 2'h0, ln, 1'h1, req_transfer_type_i,
        req_transfer_modifier_i, req_page_user_bit1_i,
        req_page_user_bit0_i});
      tk++;
    end
  task automatic reset_dut();
    rst_i = 1'h1;
    repeat (10) @(negedge core_clk_i);
    chk({transfer_start_n_o, transfer_in_progress_n_o, req_ready_o,
      rsp_valid_o, cache_inhibit_out_n_o}, 5'h19);
    rst_i = 1'h0;
    $display("test done: reset");
  endtask
  task automatic run(input pbrt_row_t r, input logic [2:0] t, d);
    ln = r.ln && d == 3'h0;
    ea = r.ins ? {r.a[31:3], 3'h0} : r.a;
    szx = ln ? PBRT_SIZE_LINE : (r.ln ? PBRT_SIZE_LONG : r.sz);
    tk0 = tk;
    @(negedge core_clk_i);
    {req_valid_i, req_addr_i, req_line_i, req_instr_i} = {1'h1, r.a, r.ln,
      r.ins};
    {req_size_i, wt, inh, late, ci} = {r.sz, r.w, r.inh, r.late, r.ci};
    {req_cache_en_i, req_cachable_i, req_implicit_nc_i, req_no_alloc_i} =
      {d != 3'h1, d != 3'h2, d == 3'h3, d == 3'h4};
    {req_transfer_type_i, req_transfer_modifier_i} = {t[1:0], t};
    {req_page_user_bit1_i, req_page_user_bit0_i} = t[2:1];
    while (req_ready_o !== 1'h1)
      @(negedge core_clk_i);
    @(negedge core_clk_i);
    req_valid_i = 1'h0;
    for (int k = 0; k < (ln ? 4 : 1); k++)
    begin
      while (rsp_valid_o !== 1'h1)
        @(negedge core_clk_i);
      chk({rsp_data_o, rsp_beat_o, rsp_last_o, rsp_cache_inhibit_o},
        {({ea[31:4], ea[3:2] + k[1:0], 2'h0} ^ 32'h5A5A_5A5A), k[1:0],
        k == (ln ? 3 : 0), ln && r.ci});
      @(negedge core_clk_i);
    end
    chk(48'(tk - tk0), ln && r.inh ? 48'h4 : 48'h1);
    $display("test done: addr %h mode %0d", r.a, d);
  endtask
  initial
  begin
    reset_dut();
    foreach (rows[i])
      run(rows[i], 3'(i), 3'h0);
    for (int d = 1; d < 5; d++)
      run(rows[4], 3'h5, 3'(d));
    reset_dut();
    run(rows[0], 3'h0, 3'h0);
    print_verdict();
  end
endmodule
